//--- pga_gen_a.sv
/*
 Generator A control: enable, buffered load-okay, reload frequency, reload flag,
 counter readback and six PWM pins, reached over AXI4-Lite.
 Assumes generators B and C are driven by this timebase while multiple timebase mode is clear.
*/
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pga_gen_a (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic [pga_pkg::NCH-1:0] pwm_o,
    output logic reload_irq_a
);
    import pga_pkg::*;

    typedef struct packed {
        logic en;
        logic ldok;
        logic rie;
        logic [3:0] ldfq_buf;
        logic half;
        logic [1:0] prsc_buf;
        logic rf;
        logic multiple_timebase_mode;
        logic center;
        logic [NCH-1:0] outctl;
        logic [NCH-1:0] outval;
        logic [14:0] mod_buf;
        logic [NCH-1:0][15:0] val_buf;
        logic [1:0] prsc_act;
        logic [14:0] mod_act;
        logic [NCH-1:0][15:0] val_act;
        logic [3:0] ldfq_act;
        logic [3:0] opp_cnt;
        logic ldok_arm;
        logic rf_arm;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NCH-1:0] pwm;
    } pga_state_t;

    pga_state_t s_r;
    pga_state_t s_nxt;
    logic [14:0] cnt;
    logic opp;
    logic reload;
    logic wr;
    logic wr_fq;
    logic [5:0] wsel;
    logic [5:0] rsel;
    logic [31:0] wm;
    logic [NCH-1:0] ch_en;

    pga_timebase u_tb (
        .mclk(mclk),
        .nrst(nrst),
        .en(s_r.en),
        .prsc(s_r.prsc_act),
        .mod(s_r.mod_act),
        .center(s_r.center),
        .half(s_r.half),
        .cnt(cnt),
        .opp(opp)
    );

    function automatic logic is_val(input logic [5:0] sel);
        is_val = (sel[5:4] == 2'h1) && !sel[0] && (sel[3:1] < 3'(NCH));
    endfunction : is_val

    always_comb begin
        s_nxt = s_r;
        wr = s_r.aw_held && s_r.w_held;
        wsel = s_r.awaddr[7:2];
        rsel = araddr[7:2];
        wm = 32'h0;
        reload = opp && (s_r.opp_cnt == s_r.ldfq_act);
        wr_fq = wr && (wsel == IDX_FQCA) && s_r.wstrb[0] && s_r.wdata[FQCA_RF_BIT];
        ch_en = {{(NCH-2){s_r.en && !s_r.multiple_timebase_mode}}, {2{s_r.en}}};
        if (awvalid && awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = wdata;
            s_nxt.wstrb = wstrb;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (wr) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            case (wsel)
                IDX_ENCA: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.en = s_r.wdata[ENCA_EN_BIT];
                        s_nxt.rie = s_r.wdata[ENCA_RIE_BIT];
                        if (!s_r.wdata[ENCA_LDOK_BIT]) begin
                            s_nxt.ldok = 1'b0;
                        end else if (s_r.ldok_arm) begin
                            s_nxt.ldok = 1'b1;
                        end
                        s_nxt.ldok_arm = 1'b0;
                    end
                end
                IDX_FQCA: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.ldfq_buf = s_r.wdata[FQCA_LDFQ_LSB +: 4];
                        s_nxt.half = s_r.wdata[FQCA_HALF_BIT];
                        s_nxt.prsc_buf = s_r.wdata[FQCA_PRSC_LSB +: 2];
                        if (wr_fq && s_r.rf_arm) begin
                            s_nxt.rf = 1'b0;
                        end
                        s_nxt.rf_arm = 1'b0;
                    end
                end
                IDX_CNTA: begin
                    s_nxt.bresp = RESP_OKAY;
                end
                IDX_MODA: begin
                    wm = pga_merge({17'h0, s_r.mod_buf}, s_r.wdata, s_r.wstrb);
                    s_nxt.mod_buf = wm[14:0];
                end
                IDX_CFG: begin
                    wm = pga_merge({10'h0, s_r.outval, 2'h0, s_r.outctl, 6'h0, s_r.center, s_r.multiple_timebase_mode},
                                   s_r.wdata, s_r.wstrb);
                    s_nxt.multiple_timebase_mode = wm[CFG_MTG_BIT];
                    s_nxt.center = wm[CFG_CENTER_BIT];
                    s_nxt.outctl = wm[CFG_OUTCTL_LSB +: NCH];
                    s_nxt.outval = wm[CFG_OUTVAL_LSB +: NCH];
                end
                default: begin
                    if (is_val(wsel)) begin
                        wm = pga_merge({16'h0, s_r.val_buf[wsel[3:1]]}, s_r.wdata, s_r.wstrb);
                        s_nxt.val_buf[wsel[3:1]] = wm[15:0];
                    end else begin
                        s_nxt.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = 32'h0;
            case (rsel)
                IDX_ENCA: begin
                    s_nxt.rdata[ENCA_EN_BIT] = s_r.en;
                    s_nxt.rdata[ENCA_LDOK_BIT] = s_r.ldok;
                    s_nxt.rdata[ENCA_RIE_BIT] = s_r.rie;
                    if (!s_r.ldok) begin
                        s_nxt.ldok_arm = 1'b1;
                    end
                end
                IDX_FQCA: begin
                    s_nxt.rdata[FQCA_LDFQ_LSB +: 4] = s_r.ldfq_buf;
                    s_nxt.rdata[FQCA_HALF_BIT] = s_r.half;
                    s_nxt.rdata[FQCA_PRSC_LSB +: 2] = s_r.prsc_buf;
                    s_nxt.rdata[FQCA_RF_BIT] = s_r.rf;
                    if (s_r.rf) begin
                        s_nxt.rf_arm = 1'b1;
                    end
                end
                IDX_CNTA: s_nxt.rdata[14:0] = cnt;
                IDX_MODA: s_nxt.rdata[14:0] = s_r.mod_buf;
                IDX_CFG: s_nxt.rdata = {10'h0, s_r.outval, 2'h0, s_r.outctl, 6'h0, s_r.center, s_r.multiple_timebase_mode};
                default: begin
                    if (is_val(rsel)) begin
                        s_nxt.rdata[15:0] = s_r.val_buf[rsel[3:1]];
                    end else begin
                        s_nxt.rresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        // Reload handling comes last so the flag set beats a clear in the same cycle
        if (opp) begin
            s_nxt.opp_cnt = reload ? 4'h0 : s_r.opp_cnt + 4'h1;
        end
        if (reload) begin
            s_nxt.rf = 1'b1;
            s_nxt.rf_arm = 1'b0;
            s_nxt.ldfq_act = s_r.ldfq_buf;
            if (s_r.ldok) begin
                s_nxt.prsc_act = s_r.prsc_buf;
                s_nxt.mod_act = s_r.mod_buf;
                s_nxt.val_act[1:0] = s_r.val_buf[1:0];
                if (!s_r.multiple_timebase_mode) begin
                    s_nxt.val_act[NCH-1:2] = s_r.val_buf[NCH-1:2];
                end
                s_nxt.ldok = 1'b0;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            s_nxt.pwm[i] = s_r.outctl[i] ? s_r.outval[i] :
                           (ch_en[i] && pga_active(s_r.val_act[i], cnt, s_r.mod_act));
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.mod_buf <= RST_MOD;
            s_r.mod_act <= RST_MOD;
            s_r.val_buf <= {NCH{RST_VAL}};
            s_r.val_act <= {NCH{RST_VAL}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = !s_r.aw_held && !s_r.bvalid;
    assign wready = !s_r.w_held && !s_r.bvalid;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = !s_r.rvalid;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign pwm_o = s_r.pwm;
    assign reload_irq_a = s_r.rf && s_r.rie;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence load_cycle;
        reload && s_r.ldok;
    endsequence

    a_flag_clear_ok: assert property (s_r.rf && wr_fq && s_r.rf_arm && !reload |=> !reload_irq_a)
        else $error("armed flag clear did not drop the request");
    a_irq_on_reload: assert property (reload |=> reload_irq_a == s_r.rie)
        else $error("reload request does not follow the enable");
    a_flag_on_reload: assert property (reload |=> s_r.rf)
        else $error("reload flag not set");
    a_ldok_autoclr: assert property (load_cycle |=> !s_r.ldok)
        else $error("load okay not cleared after load");
    a_ldok_read_first: assert property ($rose(s_r.ldok) |-> $past(s_r.ldok_arm))
        else $error("load okay set without prior read");
    a_mod_loaded: assert property (load_cycle |=> s_r.mod_act == $past(s_r.mod_buf))
        else $error("modulus not loaded");
    a_mtg_keeps_upper: assert property (load_cycle and s_r.multiple_timebase_mode |=> $stable(s_r.val_act[2]))
        else $error("upper width loaded in multiple timebase mode");
    a_freq_count: assert property (opp && !reload |=> s_r.opp_cnt == $past(s_r.opp_cnt) + 4'h1)
        else $error("opportunity count did not advance");
    a_dis_inactive: assert property (!s_r.en && !s_r.outctl[0] |=> !pwm_o[0])
        else $error("disabled pin active");
    a_mtg_upper_off: assert property (s_r.multiple_timebase_mode && !s_r.outctl[3] |=> !pwm_o[3])
        else $error("upper pin active in multiple timebase mode");
    a_rf_clear_blocked: assert property (s_r.rf && wr_fq && !s_r.rf_arm |=> s_r.rf)
        else $error("flag cleared without read");
endmodule : pga_gen_a
`default_nettype wire

//--- pga_pkg.sv
/*
 Shared constants, types and helpers for the generator A reload and control block.
 Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
`default_nettype none
package pga_pkg;
    localparam int NCH = 6;
    localparam int CW = 15;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_VAL0 = 6'h10;
    localparam logic [5:0] IDX_ENCA = 6'h20;
    localparam logic [5:0] IDX_FQCA = 6'h21;
    localparam logic [5:0] IDX_CNTA = 6'h22;
    localparam logic [5:0] IDX_MODA = 6'h24;
    localparam logic [5:0] IDX_CFG = 6'h30;
    // generator_a_enable_ctrl fields
    localparam int ENCA_EN_BIT = 7;
    localparam int ENCA_LDOK_BIT = 1;
    localparam int ENCA_RIE_BIT = 0;
    // reload_freq_ctrl_a fields
    localparam int FQCA_LDFQ_LSB = 4;
    localparam int FQCA_HALF_BIT = 3;
    localparam int FQCA_PRSC_LSB = 1;
    localparam int FQCA_RF_BIT = 0;
    // Configuration register fields
    localparam int CFG_MTG_BIT = 0;
    localparam int CFG_CENTER_BIT = 1;
    localparam int CFG_OUTCTL_LSB = 8;
    localparam int CFG_OUTVAL_LSB = 16;
    // Reset values and AXI4-Lite response codes
    localparam logic [14:0] RST_MOD = 15'h0100;
    localparam logic [15:0] RST_VAL = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} pga_dir_t;

    function automatic logic [2:0] pga_div_mask(input logic [1:0] prsc);
        pga_div_mask = 3'((4'h1 << prsc) - 4'h1);
    endfunction : pga_div_mask

    function automatic logic [31:0] pga_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            pga_merge[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : pga_merge

    // Signed width against counter: never on at or below zero, always on at or above modulus
    function automatic logic pga_active(input logic [15:0] val, input logic [14:0] cnt,
                                        input logic [14:0] mod);
        if ($signed(val) <= 16'sh0000) begin
            pga_active = 1'b0;
        end else if (val >= {1'b0, mod}) begin
            pga_active = 1'b1;
        end else begin
            pga_active = ({1'b0, cnt} < val);
        end
    endfunction : pga_active
endpackage : pga_pkg
`default_nettype wire

//--- pga_timebase.sv
/*
 Prescaler and 15-bit up or up/down counter of generator A, with reload opportunity strobe.
 Assumes prescaler and modulus change only at a reload, which falls one mclk after a prescaler tick.
*/
`timescale 1ns/1ps
`default_nettype none
module pga_timebase (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic en,
    input wire logic [1:0] prsc,
    input wire logic [14:0] mod,
    input wire logic center,
    input wire logic half,
    output logic [14:0] cnt,
    output logic opp
);
    import pga_pkg::*;

    typedef struct packed {
        logic [2:0] div;
        logic [14:0] cnt;
        pga_dir_t dir;
        logic opp;
    } pga_tb_t;

    pga_tb_t s_r;
    pga_tb_t s_nxt;
    logic tick;

    always_comb begin
        s_nxt = s_r;
        s_nxt.opp = 1'b0;
        tick = en && (s_r.div == pga_div_mask(prsc));
        if (!en) begin
            s_nxt.div = 3'h0;
            s_nxt.cnt = 15'h0;
            s_nxt.dir = DIR_UP;
        end else if (!tick) begin
            s_nxt.div = s_r.div + 3'h1;
        end else begin
            s_nxt.div = 3'h0;
            if (!center) begin
                if (s_r.cnt >= mod - 15'h1) begin
                    s_nxt.cnt = 15'h0;
                    s_nxt.opp = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + 15'h1;
                end
            end else begin
                case (s_r.dir)
                    DIR_UP: begin
                        if (s_r.cnt >= mod - 15'h1) begin
                            s_nxt.cnt = mod;
                            s_nxt.dir = DIR_DOWN;
                            s_nxt.opp = half;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 15'h1;
                        end
                    end
                    DIR_DOWN: begin
                        if (s_r.cnt <= 15'h1) begin
                            s_nxt.cnt = 15'h0;
                            s_nxt.dir = DIR_UP;
                            s_nxt.opp = 1'b1;
                        end else begin
                            s_nxt.cnt = s_r.cnt - 15'h1;
                        end
                    end
                    default: s_nxt.dir = DIR_UP;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{div: 3'h0, cnt: 15'h0, dir: DIR_UP, opp: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cnt = s_r.cnt;
    assign opp = s_r.opp;

    a_prsc_div8: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && prsc == 2'h3) ##1 (en && prsc == 2'h3) |-> (!tick) [*6])
        else $error("prescale by 8 ticked early");
endmodule : pga_timebase
`default_nettype wire

//--- pga_stage_model.sv
/*
 Power stage model on the six PWM pins: counts active cycles and rising edges per pin.
 Assumes pins are registered on mclk, active high, and a clear pulse restarts a window.
*/
`timescale 1ns/1ps
`default_nettype none
module pga_stage_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic [pga_pkg::NCH-1:0] pwm,
    output logic [pga_pkg::NCH-1:0][15:0] hi_cnt,
    output logic [pga_pkg::NCH-1:0][15:0] rise_cnt
);
    import pga_pkg::*;
    logic [NCH-1:0] prev_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt <= '0;
            rise_cnt <= '0;
            prev_r <= '0;
        end else if (clr) begin
            hi_cnt <= '0;
            rise_cnt <= '0;
            prev_r <= pwm;
        end else begin
            prev_r <= pwm;
            for (int i = 0; i < NCH; i++) begin
                hi_cnt[i] <= hi_cnt[i] + 16'(pwm[i]);
                rise_cnt[i] <= rise_cnt[i] + 16'(pwm[i] & ~prev_r[i]);
            end
        end
    end
endmodule : pga_stage_model
`default_nettype wire

//--- tb.sv
/*
 Self-checking bench for generator A: AXI4-Lite register tasks, PWM pin windows, reload timing.
 Assumes the stage model counts pin activity and the reload interrupt follows the reload flag.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pga_pkg::*;
    localparam logic [7:0] A_EN = {IDX_ENCA, 2'b00};
    localparam logic [7:0] A_FQ = {IDX_FQCA, 2'b00};
    localparam logic [7:0] A_CN = {IDX_CNTA, 2'b00};
    localparam logic [7:0] A_MD = {IDX_MODA, 2'b00};
    localparam logic [7:0] A_CF = {IDX_CFG, 2'b00};
    logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready, clr;
    logic awready, wready, bvalid, arready, rvalid, reload_irq_a;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, fq_cfg;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [NCH-1:0] pwm_o;
    logic [NCH-1:0][15:0] hi_cnt, rise_cnt;
    logic [NCH-1:0][15:0] wv = {16'd20, 16'd4, 16'hffff, 16'd16, 16'd0, 16'd8};
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int t1;

    pga_gen_a i_pga_gen_a (.mclk(mclk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .pwm_o(pwm_o), .reload_irq_a(reload_irq_a));
    pga_stage_model i_pga_stage_model (.mclk(mclk), .nrst(nrst), .clr(clr), .pwm(pwm_o),
        .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #400000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Valid and payload held until the edge where ready is seen; ready values are stable from negedge
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
        logic ah, wh, bh;
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bh = 1'b0;
        n = 0;
        while (!bh && n < 100) begin
            @(negedge mclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            resp = bresp;
            n++;
            @(posedge mclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!bh) chk(0, 1, "write timeout");
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        logic ah, rh;
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rh = 1'b0;
        n = 0;
        while (!rh && n < 100) begin
            @(negedge mclk);
            ah = arvalid & arready;
            rh = rvalid;
            dat = rdata;
            resp = rresp;
            n++;
            @(posedge mclk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!rh) chk(0, 1, "read timeout");
    endtask : rd

    task automatic load();
        logic [31:0] v;
        logic [1:0] q;
        int n;
        rd(A_EN, v, q);
        wr(A_EN, 32'h83, q);
        v = 32'h2;
        n = 0;
        while (v[1] !== 1'b0 && n < 200) begin
            rd(A_EN, v, q);
            n++;
        end
        chk(v, 32'h81, "load-okay self clear");
    endtask : load

    task automatic meas(input logic [NCH-1:0][15:0] eh, input logic [15:0] er0, input int w);
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (w) @(posedge mclk);
        @(negedge mclk);
        for (int i = 0; i < NCH; i++) chk(32'(hi_cnt[i]), 32'(eh[i]), "active cycles");
        chk(32'(rise_cnt[0]), 32'(er0), "pin0 periods");
    endtask : meas

    task automatic clr_flag();
        logic [31:0] v;
        logic [1:0] q;
        rd(A_FQ, v, q);
        wr(A_FQ, fq_cfg | 32'h1, q);
    endtask : clr_flag

    task automatic wait_irq();
        int n;
        n = 0;
        @(negedge mclk);
        while (reload_irq_a !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 1000) chk(0, 1, "no reload");
    endtask : wait_irq

    // First reload lets a new frequency take over, the second interval is measured
    task automatic gap(input int e);
        clr_flag();
        wait_irq();
        // A clear cut short by a reload leaves the flag set, so align once more
        clr_flag();
        wait_irq();
        t1 = cyc;
        clr_flag();
        wait_irq();
        chk(32'(cyc - t1), 32'(e), "reload interval");
    endtask : gap

    initial begin
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, clr} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        fq_cfg = '0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rd(A_EN, d, r); chk(d, 32'h0, "enable reset");
        rd(A_FQ, d, r); chk(d, 32'h0, "freq reset");
        rd(A_MD, d, r); chk(d, 32'(RST_MOD), "modulus reset");
        rd(A_CN, d, r); chk(d, 32'h0, "counter reset");
        rd(8'hfc, d, r); chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
        wr(8'hfc, 32'h1, r); chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
        $display("test reset done");
        wr(A_EN, 32'h0, r);
        wr(A_EN, 32'h2, r);
        rd(A_EN, d, r); chk(d, 32'h0, "load-okay without read");
        wr(A_EN, 32'h2, r);
        rd(A_EN, d, r); chk(d, 32'h2, "load-okay after read");
        wr(A_EN, 32'h0, r);
        rd(A_EN, d, r); chk(d, 32'h0, "load-okay write zero");
        $display("test load-okay done");
        wr(A_MD, 32'h10, r);
        for (int i = 0; i < NCH; i++) wr({IDX_VAL0 + 6'(2 * i), 2'b00}, 32'(wv[i]), r);
        load();
        rd(A_CN, d, r); chk(32'(d < 32'h10), 32'h1, "counter live");
        wr(A_CN, 32'h7fff, r); chk(32'(r), 32'(RESP_OKAY), "counter write");
        rd(A_CN, d, r); chk(32'(d < 32'h10), 32'h1, "counter unwritten");
        meas({16'd64, 16'd16, 16'd0, 16'd64, 16'd0, 16'd32}, 16'd4, 64);
        $display("test enable done");
        for (int p = 0; p < 4; p++) begin
            fq_cfg = 32'(p << 1);
            wr(A_FQ, fq_cfg, r);
            load();
            meas({16'd256, 16'd64, 16'd0, 16'd256, 16'd0, 16'd128}, 16'(16 >> p), 256);
        end
        fq_cfg = '0;
        wr(A_FQ, fq_cfg, r);
        meas({16'd256, 16'd64, 16'd0, 16'd256, 16'd0, 16'd128}, 16'd2, 256);
        load();
        $display("test prescaler done");
        gap(16);
        fq_cfg = 32'hf0;
        wr(A_FQ, fq_cfg, r);
        rd(A_FQ, d, r); chk(d & 32'hfe, 32'hf0, "buffered frequency");
        gap(256);
        rd(A_FQ, d, r);
        repeat (300) @(posedge mclk);
        wr(A_FQ, fq_cfg | 32'h1, r);
        @(negedge mclk);
        chk(32'(reload_irq_a), 32'h1, "stale flag clear");
        clr_flag();
        @(negedge mclk);
        chk(32'(reload_irq_a), 32'h0, "flag clear");
        fq_cfg = '0;
        wr(A_FQ, fq_cfg, r);
        gap(16);
        wr(A_EN, 32'h80, r);
        repeat (40) @(negedge mclk);
        chk(32'(reload_irq_a), 32'h0, "masked request");
        rd(A_FQ, d, r); chk(32'(d[0]), 32'h1, "flag while masked");
        wr(A_EN, 32'h81, r);
        $display("test reload done");
        fq_cfg = 32'h08;
        wr(A_FQ, fq_cfg, r);
        gap(16);
        wr(A_CF, 32'h2, r);
        gap(16);
        fq_cfg = '0;
        wr(A_FQ, fq_cfg, r);
        gap(32);
        wr(A_CF, 32'h0, r);
        $display("test half-cycle done");
        wr(A_CF, 32'h1, r);
        wr({IDX_VAL0, 2'b00}, 32'h4, r);
        wr({IDX_VAL0 + 6'h4, 2'b00}, 32'h4, r);
        load();
        meas({16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd16}, 16'd4, 64);
        wr(A_CF, 32'h0, r);
        meas({16'd64, 16'd16, 16'd0, 16'd64, 16'd0, 16'd16}, 16'd4, 64);
        $display("test timebase mode done");
        wr(A_CF, 32'h0002_0300, r);
        wr(A_EN, 32'h0, r);
        meas({16'd0, 16'd0, 16'd0, 16'd0, 16'd64, 16'd0}, 16'd0, 64);
        $display("test disable done");
        final_report();
    end
endmodule : tb
`default_nettype wire
